// ### logic/array_pkg.sv
// Constants, widths and reset values for the fuse-programmed logic array.
// Assumes a single clk_sys domain and a fixture that drives pins per cycle.
package array_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Array shape
  localparam int DED_W   = 8;
  localparam int OUTS    = 8;
  localparam int ARR_IN  = DED_W + OUTS;
  localparam int TERMS   = 8;
  localparam int ROWS    = OUTS * TERMS;
  localparam int FUSE_W  = 2 * ARR_IN;
  localparam int ADDR_W  = 7;
  ////////////////////////////////////////////////////////////////////////////
  // Programming map: rows 0..63 are product terms, then one config word
  localparam logic [6:0] CFG_ADDR    = 7'h40;
  localparam int         CFG_SEL_LSB = 0;
  localparam int         CFG_POL_LSB = 8;
  localparam int         CFG_SEC_BIT = 16;
  ////////////////////////////////////////////////////////////////////////////
  // Reset values (an intact fuse reads one)
  localparam logic [31:0] FUSE_INTACT = 32'hFFFF_FFFF;
  localparam logic [7:0]  REG_RST     = 8'h00;
  localparam logic [7:0]  PIN_RST     = 8'hFF;
  localparam logic [7:0]  EN_RST      = 8'h00;
  localparam logic [7:0]  SEL_RST     = 8'hFF;
  localparam logic [7:0]  POL_RST     = 8'hFF;
endpackage

// ### logic/array_if.sv
// Carrier between the array core and its AND-OR plane.
// Assumes both ends run combinationally within one clk_sys cycle.
`timescale 1ns/1ns
interface array_if;
  logic [array_pkg::ARR_IN-1:0]                     lits;
  logic [array_pkg::ROWS-1:0][array_pkg::FUSE_W-1:0] fuses;
  logic [array_pkg::OUTS-1:0]                       sum;
  logic [array_pkg::OUTS-1:0]                       en_term;
  modport core  (output lits, output fuses, input sum, input en_term);
  modport plane (input lits, input fuses, output sum, output en_term);
endinterface

// ### logic/sum_plane.sv
// Programmable AND plane feeding fixed OR gates, purely combinational.
// Assumes fuse row o*TERMS+t belongs to output o, term t; term 0 is the enable.
`timescale 1ns/1ns
module sum_plane #(
  parameter int OUTS  = array_pkg::OUTS,
  parameter int TERMS = array_pkg::TERMS
) (
  // Array side
  array_if.plane ai
);
  logic [array_pkg::FUSE_W-1:0] litx;

  ////////////////////////////////////////////////////////////////////////////
  // true and complement
  genvar i;
  generate
    for (i = 0; i < array_pkg::ARR_IN; i++)
    begin : g_lit
      assign litx[2*i]   = ai.lits[i];
      assign litx[2*i+1] = ~ai.lits[i];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // AND plane, fixed OR
  // An intact fuse keeps its literal; both literals intact force the term low
  genvar o;
  genvar t;
  generate
    for (o = 0; o < OUTS; o++)
    begin : g_out
      logic [TERMS-1:0] pt;
      for (t = 0; t < TERMS; t++)
      begin : g_term
        assign pt[t] = &(litx | ~ai.fuses[o*TERMS+t]);
      end
      assign ai.sum[o]     = |pt[TERMS-1:1];
      assign ai.en_term[o] = pt[0];
    end
  endgenerate
endmodule // sum_plane

// ### logic/logic_array.sv
// Fuse-programmed sum-of-products array with registered/combinational outputs,
// power-up clear, pin preload, output enable and readback security.
// Assumes all pins are asynchronous to clk_sys; programming port is same-clock.
`timescale 1ns/1ns
module logic_array (
  // Clock and power-up reset
  input  wire logic                                 clk_sys,
  input  wire logic                                 rst,
  // Dedicated array inputs
  input  wire logic [array_pkg::DED_W-1:0]          in_pin,
  // Output enable pin, active low
  input  wire logic                                 out_en_n,
  // Preload pulse pin, high while at preload_pulse_level
  input  wire logic                                 preload_pulse_level,
  // Three-state I/O pins
  input  wire logic [array_pkg::OUTS-1:0]           io_pin_level,
  output logic      [array_pkg::OUTS-1:0]           io_pin_drive,
  output logic      [array_pkg::OUTS-1:0]           io_pin_en,
  // Fuse programming
  input  wire logic                                 prog_wr,
  input  wire logic [array_pkg::ADDR_W-1:0]         prog_addr,
  input  wire logic [array_pkg::FUSE_W-1:0]         prog_data,
  // Fuse readback
  input  wire logic                                 rd_req,
  input  wire logic [array_pkg::ADDR_W-1:0]         rd_addr,
  output logic      [array_pkg::FUSE_W-1:0]         rd_data,
  output logic                                      rd_valid,
  output logic                                      rd_refused
);
  localparam int OUTS = array_pkg::OUTS;
  localparam int DW   = array_pkg::DED_W;
  localparam int FW   = array_pkg::FUSE_W;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [1:0][DW-1:0]              in_sy;
    logic [1:0][OUTS-1:0]            io_sy;
    logic [1:0]                      oe_n_sy;
    logic [1:0]                      pre_sy;
    logic [OUTS-1:0]                 q;
    logic [OUTS-1:0]                 drive;
    logic [OUTS-1:0]                 drv_en;
    logic [array_pkg::ROWS-1:0][FW-1:0] fuse;
    logic [OUTS-1:0]                 reg_sel;
    logic [OUTS-1:0]                 pol;
    logic                            sec_intact;
    logic [FW-1:0]                   rd_data;
    logic                            rd_valid;
    logic                            rd_refused;
  } state_t;

  state_t          s_ff;
  state_t          nxt_s;
  logic [OUTS-1:0] feedback;
  logic [FW-1:0]   cfg_word;

  array_if ai ();

  sum_plane #(
    .OUTS  (OUTS),
    .TERMS (array_pkg::TERMS)
  ) u_plane (
    .ai (ai)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Array hookup
  // combinational outputs re-enter from the pins, registered ones from the inverted register
  always_comb
  begin
    for (int o = 0; o < OUTS; o++)
    begin
      feedback[o] = s_ff.reg_sel[o] ? ~s_ff.q[o] : s_ff.io_sy[1][o];
    end
  end

  assign ai.lits  = {feedback, s_ff.in_sy[1]};
  assign ai.fuses = s_ff.fuse;

  assign cfg_word = {{(FW-17){1'b0}}, s_ff.sec_intact, s_ff.pol, s_ff.reg_sel};

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    nxt_s = s_ff;

    // Pins cross into clk_sys through two flops before use
    nxt_s.in_sy[0]   = in_pin;
    nxt_s.in_sy[1]   = s_ff.in_sy[0];
    nxt_s.io_sy[0]   = io_pin_level;
    nxt_s.io_sy[1]   = s_ff.io_sy[0];
    nxt_s.oe_n_sy[0] = out_en_n;
    nxt_s.oe_n_sy[1] = s_ff.oe_n_sy[0];
    nxt_s.pre_sy[0]  = preload_pulse_level;
    nxt_s.pre_sy[1]  = s_ff.pre_sy[0];

    for (int o = 0; o < OUTS; o++)
    begin
      if (s_ff.reg_sel[o])
      begin
        if (s_ff.pre_sy[1])
        begin
          nxt_s.q[o] = ~s_ff.io_sy[1][o];
        end
        else
        begin
          nxt_s.q[o] = s_ff.pol[o] ? ~ai.sum[o] : ai.sum[o];
        end
        nxt_s.drive[o]  = ~nxt_s.q[o];
        nxt_s.drv_en[o] = ~s_ff.oe_n_sy[1];
      end
      else
      begin
        nxt_s.q[o]      = s_ff.q[o];
        nxt_s.drive[o]  = s_ff.pol[o] ? ai.sum[o] : ~ai.sum[o];
        nxt_s.drv_en[o] = ai.en_term[o];
      end
    end

    // Fuses only ever blow: a written zero clears, a one leaves the fuse alone
    if (prog_wr)
    begin
      if (prog_addr < array_pkg::CFG_ADDR)
      begin
        nxt_s.fuse[prog_addr[5:0]] = s_ff.fuse[prog_addr[5:0]] & prog_data;
      end
      else if (prog_addr == array_pkg::CFG_ADDR)
      begin
        nxt_s.reg_sel    = s_ff.reg_sel & prog_data[array_pkg::CFG_SEL_LSB +: OUTS];
        nxt_s.pol        = s_ff.pol & prog_data[array_pkg::CFG_POL_LSB +: OUTS];
        nxt_s.sec_intact = s_ff.sec_intact & prog_data[array_pkg::CFG_SEC_BIT];
      end
    end

    // Readback answers one cycle after the request
    nxt_s.rd_valid   = rd_req;
    nxt_s.rd_refused = 1'b0;
    nxt_s.rd_data    = '0;
    if (rd_req)
    begin
      if (!s_ff.sec_intact)
      begin
        nxt_s.rd_refused = 1'b1;
      end
      else if (rd_addr < array_pkg::CFG_ADDR)
      begin
        nxt_s.rd_data = s_ff.fuse[rd_addr[5:0]];
      end
      else if (rd_addr == array_pkg::CFG_ADDR)
      begin
        nxt_s.rd_data = cfg_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // Reset stands in for power-up, so the fuse image also returns to intact;
  // a fixture must reprogram after every reset.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_ff            <= '0;
      s_ff.q          <= array_pkg::REG_RST;
      s_ff.drive      <= array_pkg::PIN_RST;
      s_ff.drv_en     <= array_pkg::EN_RST;
      s_ff.fuse       <= {array_pkg::ROWS{array_pkg::FUSE_INTACT}};
      s_ff.reg_sel    <= array_pkg::SEL_RST;
      s_ff.pol        <= array_pkg::POL_RST;
      s_ff.sec_intact <= 1'b1;
      s_ff.oe_n_sy    <= 2'b11;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flop
  assign io_pin_drive = s_ff.drive;
  assign io_pin_en    = s_ff.drv_en;
  assign rd_data      = s_ff.rd_data;
  assign rd_valid     = s_ff.rd_valid;
  assign rd_refused   = s_ff.rd_refused;
endmodule // logic_array

// ### dv/logic_array_sva.sv
// Checker on the logic array ports.
// Assumes bind to logic_array; tracks config writes itself.
`timescale 1ns/1ns
module logic_array_sva (
  // Clock, reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Pins
  input wire logic        out_en_n,
  input wire logic        preload_pulse_level,
  input wire logic [7:0]  io_pin_level,
  input wire logic [7:0]  io_pin_drive,
  input wire logic [7:0]  io_pin_en,
  // Fuse port
  input wire logic        prog_wr,
  input wire logic [6:0]  prog_addr,
  input wire logic [31:0] prog_data,
  input wire logic        rd_req,
  input wire logic [31:0] rd_data,
  input wire logic        rd_valid,
  input wire logic        rd_refused
);
  logic [2:0] quiet_ff;
  logic [7:0] sel_ff;
  logic [7:0] pol_ff;
  logic       intact_ff;
  // Cycles since reset or preload; sync stages must flush first
  always_ff @(posedge clk_sys)
  begin
    if (rst || preload_pulse_level)
      quiet_ff <= 3'h0;
    else if (quiet_ff != 3'h7)
      quiet_ff <= quiet_ff + 3'h1;
    if (rst)
    begin
      sel_ff <= 8'hFF;
      pol_ff <= 8'hFF;
      intact_ff <= 1'b1;
    end
    else if (prog_wr && prog_addr == array_pkg::CFG_ADDR)
    begin
      sel_ff <= sel_ff & prog_data[7:0];
      pol_ff <= pol_ff & prog_data[15:8];
    end
    else if (prog_wr && prog_addr < array_pkg::CFG_ADDR)
      intact_ff <= 1'b0;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  a_reset_state: assert property (disable iff (1'b0) rst |=> io_pin_drive == 8'hFF && io_pin_en == 8'h00)
    else $error("reset state wrong");
  a_enable_follow: assert property (quiet_ff >= 3'h4 |->
    ((io_pin_en ^ ~{8{$past(out_en_n, 3)}}) & $past(sel_ff)) == 8'h00) else $error("enable wrong");
  a_preload_load: assert property ($past(preload_pulse_level, 3) && !$past(rst, 3) |->
    ((io_pin_drive ^ $past(io_pin_level, 3)) & $past(sel_ff)) == 8'h00) else $error("preload wrong");
  a_idle_polarity: assert property (intact_ff && quiet_ff >= 3'h4 |-> io_pin_drive == ~$past(pol_ff))
    else $error("polarity wrong");
  a_comb_float: assert property (intact_ff && quiet_ff >= 3'h4 |-> (io_pin_en & ~$past(sel_ff)) == 8'h00)
    else $error("comb enable wrong");
  a_read_answer: assert property (rd_req |=> rd_valid) else $error("no read answer");
  a_read_quiet: assert property (!rd_req |=> !rd_valid && !rd_refused) else $error("stray read answer");
  a_refuse_zero: assert property (rd_refused |-> rd_valid && rd_data == 32'h0000_0000) else $error("refused data");
  c_preload: cover property (preload_pulse_level ##3 preload_pulse_level);
  c_read: cover property (rd_valid);
  c_enabled: cover property (io_pin_en == 8'hFF);
endmodule // logic_array_sva
bind logic_array logic_array_sva chk (.clk_sys, .rst, .out_en_n, .preload_pulse_level, .io_pin_level, .io_pin_drive,
  .io_pin_en, .prog_wr, .prog_addr, .prog_data, .rd_req, .rd_data, .rd_valid, .rd_refused);

// ### dv/pin_fixture.sv
// Test fixture on the three-state pins.
// Assumes the bench forces only while outputs are disabled.
`timescale 1ns/1ns
module pin_fixture (
  // Clock
  input  wire logic       clk_sys,
  // Device side
  input  wire logic [7:0] io_pin_drive,
  input  wire logic [7:0] io_pin_en,
  // Forcing
  input  wire logic       force_on,
  input  wire logic [7:0] force_val,
  // Resolved pins
  output logic      [7:0] io_pin_level
);
  logic [7:0] last_ff = 8'h00;
  // forced data only on floating pins
  // Undriven pins invert each cycle so no stale level passes
  assign io_pin_level = (io_pin_en & io_pin_drive) | (~io_pin_en & (force_on ? force_val : ~last_ff));
  always @(posedge clk_sys)
    last_ff <= io_pin_level;
endmodule // pin_fixture

// ### dv/logic_array_tb.sv
// Bench for logic_array: reset, enable, preload, polarity, readback.
// Assumes 50 MHz clk_sys and pin_fixture on the pins.
`timescale 1ns/1ns
module logic_array_tb;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  in_pin = 8'h00;
  logic        out_en_n = 1'b1;
  logic        preload_pulse_level = 1'b0;
  logic        prog_wr = 1'b0;
  logic [6:0]  prog_addr = 7'h00;
  logic [31:0] prog_data = 32'h0000_0000;
  logic        rd_req = 1'b0;
  logic [6:0]  rd_addr = 7'h00;
  logic        force_on = 1'b0;
  logic [7:0]  force_val = 8'h00;
  logic [7:0]  io_pin_level;
  logic [7:0]  io_pin_drive;
  logic [7:0]  io_pin_en;
  logic [31:0] rd_data;
  logic        rd_valid;
  logic        rd_refused;
  int          failures = 0;
  int          n_checks = 0;
  int          cycles = 0;
  logic_array dut (.clk_sys, .rst, .in_pin, .out_en_n, .preload_pulse_level, .io_pin_level, .io_pin_drive,
    .io_pin_en, .prog_wr, .prog_addr, .prog_data, .rd_req, .rd_addr, .rd_data, .rd_valid, .rd_refused);
  pin_fixture fx (.clk_sys, .io_pin_drive, .io_pin_en, .force_on, .force_val, .io_pin_level);
  always #10 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // A hang ends the run at 3000 cycles, well past the expected 47 or so cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      wrap_up();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic prog(input logic [6:0] a, input logic [31:0] d);
    prog_wr = 1'b1;
    prog_addr = a;
    prog_data = d;
    tick(1);
    prog_wr = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic exp_ref);
    rd_req = 1'b1;
    rd_addr = a;
    tick(1);
    rd_req = 1'b0;
    chk({30'h0000_0000, rd_valid, rd_refused}, {30'h0000_0000, 1'b1, exp_ref});
  endtask
  ////////////////////////////////////////
  task automatic t_enable();
    out_en_n = 1'b0;
    tick(4);
    chk({24'h00_0000, io_pin_en}, 32'h0000_00FF);
    chk({24'h00_0000, io_pin_drive}, 32'h0000_0000);
    out_en_n = 1'b1;
    tick(4);
    chk({24'h00_0000, io_pin_en}, 32'h0000_0000);
  endtask
  task automatic t_preload();
    in_pin = 8'h5A;
    force_val = 8'hA5;
    force_on = 1'b1;
    tick(1);
    preload_pulse_level = 1'b1;
    tick(4);
    chk({24'h00_0000, io_pin_drive}, 32'h0000_00A5);
    chk({24'h00_0000, io_pin_en}, 32'h0000_0000);
    preload_pulse_level = 1'b0;
    tick(1);
    force_on = 1'b0;
    out_en_n = 1'b0;
    tick(4);
    chk({24'h00_0000, io_pin_drive}, 32'h0000_0000);
  endtask
  task automatic t_polarity();
    // Upper ones keep the security fuse intact
    prog(array_pkg::CFG_ADDR, 32'hFFFF_3C0F);
    tick(4);
    chk({24'h00_0000, io_pin_drive}, 32'h0000_00C3);
    chk({24'h00_0000, io_pin_en}, 32'h0000_000F);
    // Output 0 term 1 keeps only the true literal of in_pin[0]
    in_pin = 8'h5B;
    prog(7'h01, 32'h0000_0001);
    tick(4);
    chk({24'h00_0000, io_pin_drive}, 32'h0000_00C2);
  endtask
  task automatic t_readback();
    rd(7'h05, 1'b0);
    chk(rd_data, array_pkg::FUSE_INTACT);
    tick(1);
    prog(7'h05, 32'h0000_1234);
    tick(1);
    rd(7'h05, 1'b0);
    chk(rd_data, 32'h0000_1234);
    tick(1);
    rd(array_pkg::CFG_ADDR, 1'b0);
    chk(rd_data, 32'h0001_3C0F);
    tick(1);
    rd(7'h41, 1'b0);
    chk(rd_data, 32'h0000_0000);
  endtask
  task automatic t_secure();
    // Blowing only the security fuse leaves select and polarity alone
    prog(array_pkg::CFG_ADDR, 32'hFFFE_FFFF);
    tick(1);
    rd(7'h05, 1'b1);
    chk(rd_data, 32'h0000_0000);
    tick(1);
    rd(array_pkg::CFG_ADDR, 1'b1);
    chk(rd_data, 32'h0000_0000);
  endtask
  initial
  begin
    // inputs settle before the first edge after reset
    tick(4);
    chk({16'h0000, io_pin_drive, io_pin_en}, {16'h0000, array_pkg::PIN_RST, array_pkg::EN_RST});
    rst = 1'b0;
    tick(1);
    t_enable();
    t_preload();
    t_polarity();
    t_readback();
    t_secure();
    wrap_up();
  end
endmodule // logic_array_tb
